// File: pkg/wid_pkg.sv
// Purpose: shared constants for the wake-up and interrupt dispatcher
// Assumes: one core clock, synchronous active-high reset
// Notes:   power modes, vectors and flag positions
package wid_pkg;
   typedef enum logic [1:0] {
      WID_MODE_NORMAL,
      WID_MODE_GREEN,
      WID_MODE_IDLE,
      WID_MODE_SLEEP
   } wid_mode_e;

   localparam int          WID_PC_W        = 10;
   localparam logic [9:0]  WID_INT_VECTOR  = 10'h008;
   localparam logic [9:0]  WID_RESET_ADDR  = 10'h000;
   // flag positions in the pending vector
   localparam int          WID_F_TIMER     = 0;
   localparam int          WID_F_PIN       = 1;
   localparam int          WID_F_EXT0      = 2;
   localparam int          WID_F_CMP       = 3;
   localparam int          WID_NFLAG       = 4;
   localparam logic [3:0]  WID_FLAG_RESET  = 4'h0;
   localparam logic        WID_GIE_RESET   = 1'b0;
   // system reset pulse length in core clocks
   localparam int          WID_RST_CYCLES  = 4;
endpackage : wid_pkg

// File: hdl/wid_sync.sv
// Purpose: three-stage synchroniser with agreement-based change detect
// Assumes: input is asynchronous to mclk
// Notes:   stage one is read only by stage two
`timescale 1ns/100ps
module wid_sync (
   // clock and control
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // async level in
   input  wire logic din,
   // clean level and change pulse
   output logic      level,
   output logic      changed
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
      end else if (ce) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // accept a new level only once stages two and three agree
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
         end
      end
   end

   assign level   = level_reg;
   assign changed = ce && (s2_reg == s3_reg) && (s3_reg != level_reg);
endmodule : wid_sync

// File: hdl/wid_reset_gen.sv
// Purpose: turns watchdog and low-voltage events into a reset pulse
// Assumes: events are same-clock strobes
// Notes:   pulse length fixed by package constant
`timescale 1ns/100ps
module wid_reset_gen #(
   parameter int RST_CYCLES = wid_pkg::WID_RST_CYCLES
) (
   // clock and control
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // reset causes
   input  wire logic wdt_timeout,
   input  wire logic lvr_event,
   // reset out
   output logic      sys_reset
);
   // the pulse counter is eight bits wide
   if (RST_CYCLES < 1 || RST_CYCLES > 255) begin : g_bad_rst_cycles
      $error("wid_reset_gen: RST_CYCLES out of range");
   end

   logic [7:0] cnt_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= 8'h00;
      end else if (ce) begin
         if (wdt_timeout || lvr_event) begin
            cnt_reg <= 8'(RST_CYCLES);
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end

   // pin reset also holds the core in reset
   assign sys_reset = rst || (cnt_reg != 8'h00);
endmodule : wid_reset_gen

// File: hdl/wid_dispatch.sv
// Purpose: per-mode wake, flag and vector dispatch of interrupt sources
// Assumes: cpu takes one redirect per pulse; events on mclk except pins
// Notes:
`timescale 1ns/100ps
module wid_dispatch #(
   parameter int PC_W       = wid_pkg::WID_PC_W,
   parameter int RST_CYCLES = wid_pkg::WID_RST_CYCLES
) (
   // clock, reset, enable
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire logic            ce,
   // pins from outside the clock domain
   input  wire logic            ext_int_pin,
   input  wire logic [7:0]      port6_pins,
   // same-clock event strobes
   input  wire logic            timer_ovf,
   input  wire logic            cmp_change,
   input  wire logic            wdt_timeout,
   input  wire logic            lvr_event,
   // cpu instruction strobes
   input  wire logic            sleep_instr,
   input  wire logic            idle_instr,
   input  wire logic            green_instr,
   input  wire logic            normal_instr,
   input  wire logic            global_int_on_instr,
   input  wire logic            global_int_off_instr,
   // enables
   input  wire logic            ext_int_en,
   input  wire logic            pin_change_wake_en,
   input  wire logic            pin_change_int_en,
   input  wire logic            timer_ovf_int_en,
   input  wire logic            cmp_wake_en,
   input  wire logic            cmp_int_en,
   // flag clears from software
   input  wire logic [3:0]      flag_clear,
   // flags and state
   output logic                 ext_ext_int_pin_flag,
   output logic                 pin_change_flag,
   output logic                 timer_ovf_flag,
   output logic                 cmp_flag,
   output logic                 global_int_on,
   output logic [1:0]           power_mode,
   output logic                 clocks_run,
   // cpu redirect
   output logic                 sys_reset,
   output logic                 branch_valid,
   output logic [PC_W-1:0]      branch_addr,
   output logic                 wake_pulse
);
   // four bits still hold the vector; a pc wider than 16 bits is rejected
   if (PC_W < 4 || PC_W > 16) begin : g_bad_pc_w
      $error("wid_dispatch: PC_W out of range");
   end

   wid_pkg::wid_mode_e            mode_reg;
   logic [wid_pkg::WID_NFLAG-1:0] flag_reg;
   logic [wid_pkg::WID_NFLAG-1:0] flag_set;
   logic [wid_pkg::WID_NFLAG-1:0] flag_next;
   logic                          gie_reg;
   logic                          branch_reg;
   logic [PC_W-1:0]               addr_reg;
   logic                          wake_reg;
   logic                          ext_lvl;
   logic                          ext_chg;
   logic [7:0]                    p6_chg;
   logic                          pin_chg;
   logic                          ext_ev;
   logic                          asleep;
   logic                          is_idle;
   logic                          do_wake;
   logic                          do_vec;
   logic                          do_next;
   logic                          rst_core;
   logic                          rst_d_reg;

   function automatic logic low_power(input wid_pkg::wid_mode_e m);
      low_power = (m == wid_pkg::WID_MODE_SLEEP) ||
                  (m == wid_pkg::WID_MODE_IDLE);
   endfunction : low_power

   // ext pin and timer sources are dead while the core sleeps
   function automatic logic src_live(input wid_pkg::wid_mode_e m);
      src_live = (m != wid_pkg::WID_MODE_SLEEP);
   endfunction : src_live

   // mode strobes; sleep wins when several arrive together
   function automatic wid_pkg::wid_mode_e run_mode_next(
      input wid_pkg::wid_mode_e m,
      input logic               slp,
      input logic               idl,
      input logic               grn,
      input logic               nrm
   );
      run_mode_next = m;
      if (slp) begin
         run_mode_next = wid_pkg::WID_MODE_SLEEP;
      end else if (idl) begin
         run_mode_next = wid_pkg::WID_MODE_IDLE;
      end else if (grn) begin
         run_mode_next = wid_pkg::WID_MODE_GREEN;
      end else if (nrm) begin
         run_mode_next = wid_pkg::WID_MODE_NORMAL;
      end
   endfunction : run_mode_next

   wid_sync u_ext_sync (
      .mclk    (mclk),
      .rst     (rst),
      .ce      (ce),
      .din     (ext_int_pin),
      .level   (ext_lvl),
      .changed (ext_chg)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p6
         wid_sync u_p6_sync (
            .mclk    (mclk),
            .rst     (rst),
            .ce      (ce),
            .din     (port6_pins[gi]),
            .level   (),
            .changed (p6_chg[gi])
         );
      end
   endgenerate

   wid_reset_gen #(
      .RST_CYCLES (RST_CYCLES)
   ) u_rst_gen (
      .mclk        (mclk),
      .rst         (rst),
      .ce          (ce),
      .wdt_timeout (wdt_timeout),
      .lvr_event   (lvr_event),
      .sys_reset   (rst_core)
   );

   // external interrupt on falling edge of the pin
   assign ext_ev  = ext_chg && ext_lvl;
   assign pin_chg = |p6_chg;
   assign asleep  = low_power(mode_reg);
   assign is_idle = (mode_reg == wid_pkg::WID_MODE_IDLE);

   always_comb begin
      flag_set = '0;
      do_wake  = 1'b0;
      if (ext_ev && ext_int_en && src_live(mode_reg)) begin
         flag_set[wid_pkg::WID_F_EXT0] = 1'b1;
         do_wake = do_wake || is_idle;
      end
      if (pin_chg && pin_change_int_en) begin
         flag_set[wid_pkg::WID_F_PIN] = 1'b1;
      end
      if (pin_chg && pin_change_wake_en && asleep) begin
         do_wake = 1'b1;
      end
      if (timer_ovf && timer_ovf_int_en && src_live(mode_reg)) begin
         flag_set[wid_pkg::WID_F_TIMER] = 1'b1;
         do_wake = do_wake || is_idle;
      end
      if (cmp_change && cmp_int_en) begin
         flag_set[wid_pkg::WID_F_CMP] = 1'b1;
      end
      if (cmp_change && cmp_wake_en && asleep) begin
         do_wake = 1'b1;
      end
   end

   // wake only from low power
   // a wake-only event in sleep/idle with no flag still resumes
   always_comb begin
      do_vec  = 1'b0;
      do_next = 1'b0;
      if (asleep) begin
         if (do_wake) begin
            do_vec  = gie_reg && (|flag_set);
            do_next = !do_vec;
         end
      end else if (|flag_set) begin
         do_vec  = gie_reg;
         do_next = !gie_reg;
      end
   end

   // set beats clear: an event in the clearing cycle is kept
   genvar fi;
   generate
      for (fi = 0; fi < wid_pkg::WID_NFLAG; fi++) begin : g_flag
         assign flag_next[fi] = flag_set[fi] ||
                                (flag_reg[fi] && !flag_clear[fi]);
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst_core) begin
         flag_reg <= wid_pkg::WID_FLAG_RESET;
      end else if (ce) begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst_core) begin
         gie_reg <= wid_pkg::WID_GIE_RESET;
      end else if (ce) begin
         if (do_vec) begin
            // vector entry masks further interrupts
            gie_reg <= 1'b0;
         end else if (global_int_on_instr) begin
            gie_reg <= 1'b1;
         end else if (global_int_off_instr) begin
            gie_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst_core) begin
         mode_reg <= wid_pkg::WID_MODE_NORMAL;
      end else if (ce) begin
         unique case (mode_reg)
            // only a wake or a reset leaves sleep and idle
            wid_pkg::WID_MODE_SLEEP, wid_pkg::WID_MODE_IDLE: begin
               if (do_wake) begin
                  mode_reg <= wid_pkg::WID_MODE_NORMAL;
               end
            end
            wid_pkg::WID_MODE_GREEN, wid_pkg::WID_MODE_NORMAL: begin
               mode_reg <= run_mode_next(mode_reg, sleep_instr,
                                         idle_instr, green_instr,
                                         normal_instr);
            end
         endcase
      end
   end

   // redirect to the cpu; wake pulse marks resume
   always_ff @(posedge mclk) begin
      if (rst) begin
         rst_d_reg  <= 1'b1;
         branch_reg <= 1'b0;
         addr_reg   <= '0;
         wake_reg   <= 1'b0;
      end else if (ce) begin
         rst_d_reg <= rst_core;
         wake_reg  <= do_wake && !rst_core;
         if (rst_core) begin
            branch_reg <= 1'b0;
            addr_reg   <= PC_W'(wid_pkg::WID_RESET_ADDR);
         end else if (rst_d_reg) begin
            branch_reg <= 1'b1;
            addr_reg   <= PC_W'(wid_pkg::WID_RESET_ADDR);
         end else if (do_vec) begin
            branch_reg <= 1'b1;
            addr_reg   <= PC_W'(wid_pkg::WID_INT_VECTOR);
         end else begin
            branch_reg <= 1'b0;
         end
      end
   end

   assign ext_ext_int_pin_flag   = flag_reg[wid_pkg::WID_F_EXT0];
   assign pin_change_flag = flag_reg[wid_pkg::WID_F_PIN];
   assign timer_ovf_flag  = flag_reg[wid_pkg::WID_F_TIMER];
   assign cmp_flag        = flag_reg[wid_pkg::WID_F_CMP];
   assign global_int_on   = gie_reg;
   assign power_mode      = mode_reg;
   assign clocks_run      = !asleep;
   assign sys_reset       = rst_core;
   assign branch_valid    = branch_reg;
   assign branch_addr     = addr_reg;
   assign wake_pulse      = wake_reg;
   // do_next needs no port: no redirect means the cpu runs on
   logic unused_next;
   assign unused_next = do_next;
endmodule : wid_dispatch

// File: sim/wid_dispatch_asserts.sv
// Purpose: port properties of the dispatcher
// Assumes: ce held high by the bench
// Notes:   bound to every dispatcher instance
`timescale 1ns/100ps
module wid_dispatch_asserts #(
   parameter int PC_W = wid_pkg::WID_PC_W
) (
   // clock and reset
   input wire logic            mclk,
   input wire logic            rst,
   // events and controls
   input wire logic            timer_ovf,
   input wire logic            timer_ovf_int_en,
   input wire logic            wdt_timeout,
   input wire logic            lvr_event,
   input wire logic [3:0]      flag_clear,
   // outputs watched
   input wire logic            pin_change_flag,
   input wire logic            timer_ovf_flag,
   input wire logic            global_int_on,
   input wire logic [1:0]      power_mode,
   input wire logic            clocks_run,
   input wire logic            sys_reset,
   input wire logic            branch_valid,
   input wire logic [PC_W-1:0] branch_addr,
   input wire logic            wake_pulse
);
   logic quiet;
   // resets wipe flags, so those cycles are left out
   assign quiet = !sys_reset && !wdt_timeout && !lvr_event;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   run_no_wake_a: assert property (
      power_mode < 2'h2 |=> !wake_pulse)
      else $error("wake pulse in run mode");
   stop_clk_a: assert property (
      power_mode >= 2'h2 |-> !clocks_run)
      else $error("clocks run while asleep");
   sleep_tmr_a: assert property (
      power_mode == 2'h3 && timer_ovf && !timer_ovf_flag |=> !timer_ovf_flag)
      else $error("timer flagged in sleep");
   idle_wake_a: assert property (
      power_mode == 2'h2 && timer_ovf && timer_ovf_int_en && quiet
      |=> wake_pulse && timer_ovf_flag && power_mode == 2'h0)
      else $error("idle timer wake missing");
   vec_gie_a: assert property (
      branch_valid && branch_addr == wid_pkg::WID_INT_VECTOR
      |-> $past(global_int_on)) else $error("vector without enable");
   wdt_rst_a: assert property (
      wdt_timeout |=> sys_reset ##1 (sys_reset && power_mode == 2'h0) [*2])
      else $error("watchdog reset missing");
   lvr_rst_a: assert property (
      lvr_event |=> sys_reset ##1 (sys_reset && power_mode == 2'h0) [*2])
      else $error("low-voltage reset missing");
   restart_zero_a: assert property (
      $fell(sys_reset) |=> branch_valid
      && branch_addr == wid_pkg::WID_RESET_ADDR) else $error("no restart");
   pin_hold_a: assert property (
      pin_change_flag && !flag_clear[1] && quiet |=> pin_change_flag)
      else $error("pin flag lost");
endmodule : wid_dispatch_asserts

bind wid_dispatch wid_dispatch_asserts #(.PC_W(PC_W)) u_chk (
   .mclk, .rst, .timer_ovf, .timer_ovf_int_en, .wdt_timeout, .lvr_event,
   .flag_clear, .pin_change_flag, .timer_ovf_flag, .global_int_on,
   .power_mode, .clocks_run, .sys_reset, .branch_valid, .branch_addr,
   .wake_pulse
);

// File: sim/wid_cpu_model.sv
// Purpose: cpu side issuing mode and global enable strobes
// Assumes: strobes change on falling mclk, one cycle wide
// Notes:   pc follows redirects, holds on wake
`timescale 1ns/100ps
module wid_cpu_model (
   // clock
   input  wire logic       mclk,
   // redirect from dispatcher
   input  wire logic       branch_valid,
   input  wire logic [9:0] branch_addr,
   input  wire logic       wake_pulse,
   // 0 normal 1 green 2 idle 3 sleep 4 on 5 off
   output logic [5:0]      instr
);
   logic [9:0] pc_reg;
   initial instr = 6'h00;
   always_ff @(posedge mclk) begin
      if (branch_valid) pc_reg <= branch_addr;
      else if (!wake_pulse) pc_reg <= pc_reg + 10'h001;
   end
   task automatic issue(input int k);
      @(negedge mclk);
      instr[k] = 1'b1;
      @(negedge mclk);
      instr[k] = 1'b0;
   endtask : issue
endmodule : wid_cpu_model

// File: sim/tb.sv
// Purpose: self-checking bench for the wake dispatcher
// Assumes: inputs change on falling mclk
// Notes:   one case per mode, source and enable set
`timescale 1ns/100ps
module tb;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       ext_int_pin = 1'b1;
   logic [7:0] port6_pins = 8'h00;
   logic [3:0] ev = 4'h0;
   logic [5:0] en = 6'h00;
   logic [3:0] flag_clear = 4'h0;
   logic [5:0] instr;
   logic       ext_ext_int_pin_flag, pin_change_flag, timer_ovf_flag, cmp_flag;
   logic       global_int_on, clocks_run, sys_reset, branch_valid;
   logic       wake_pulse;
   logic [1:0] power_mode;
   logic [9:0] branch_addr;
   logic [3:0] flg;
   logic [9:0] exp_q[$];
   int         err_total = 0;
   int         checked = 0;
   int         wk = 0;
   assign flg = {cmp_flag, ext_ext_int_pin_flag, pin_change_flag, timer_ovf_flag};
   always #10 mclk = ~mclk;
   wid_dispatch DUT (
      .mclk, .rst, .ce(1'b1), .ext_int_pin, .port6_pins,
      .timer_ovf(ev[0]), .cmp_change(ev[1]), .wdt_timeout(ev[2]),
      .lvr_event(ev[3]), .sleep_instr(instr[3]), .idle_instr(instr[2]),
      .green_instr(instr[1]), .normal_instr(instr[0]),
      .global_int_on_instr(instr[4]), .global_int_off_instr(instr[5]),
      .ext_int_en(en[0]), .pin_change_wake_en(en[1]),
      .pin_change_int_en(en[2]), .timer_ovf_int_en(en[3]),
      .cmp_wake_en(en[4]), .cmp_int_en(en[5]), .flag_clear,
      .ext_ext_int_pin_flag, .pin_change_flag, .timer_ovf_flag, .cmp_flag,
      .global_int_on, .power_mode, .clocks_run, .sys_reset,
      .branch_valid, .branch_addr, .wake_pulse
   );
   wid_cpu_model cpu (.mclk, .branch_valid, .branch_addr, .wake_pulse,
      .instr);
   task automatic chk(input string n, input logic [9:0] e, g);
      checked++;
      if (e !== g) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // oldest noted redirect against each branch pulse
   always @(negedge mclk) begin
      if (wake_pulse === 1'b1) wk++;
      if (branch_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("extra branch", 10'h3FF, branch_addr);
         end else begin
            chk("branch", exp_q.pop_front(), branch_addr);
         end
      end
   end
   task automatic do_reset(input int n);
      rst = 1'b1;
      ext_int_pin = 1'b1;
      port6_pins = 8'h00;
      en = 6'h00;
      repeat (n) @(negedge mclk);
      exp_q.push_back(wid_pkg::WID_RESET_ADDR);
      rst = 1'b0;
      // let the pin synchronisers settle before enabling
      repeat (8) @(negedge mclk);
   endtask : do_reset
   // s: 0 timer 1 pin 2 ext 3 cmp 4 wdt 5 lvr; b: 1 vector 2 restart
   task automatic tc(input int m, s, input logic [5:0] e, input logic g,
                     input logic [3:0] ef, input int w, b, em);
      do_reset(2);
      en = e;
      cpu.issue(g ? 4 : 5);
      if (m != 0) cpu.issue(m);
      @(negedge mclk);
      wk = 0;
      if (b == 1) exp_q.push_back(wid_pkg::WID_INT_VECTOR);
      if (b == 2) exp_q.push_back(wid_pkg::WID_RESET_ADDR);
      if (s == 1) port6_pins = 8'($urandom % 255 + 1);
      else if (s == 2) ext_int_pin = 1'b0;
      else ev[s == 0 ? 0 : s - 2] = 1'b1;
      @(negedge mclk);
      ev = 4'h0;
      // pins pass three sync stages plus agreement
      repeat (14) @(negedge mclk);
      chk("queue", 10'h000, 10'(exp_q.size()));
      chk("flags", 10'(ef), 10'(flg));
      chk("mode", 10'(em), 10'(power_mode));
      if (s < 4) chk("wake", 10'(w), 10'(wk));
      flag_clear = 4'hF;
      @(negedge mclk);
      flag_clear = 4'h0;
      @(negedge mclk);
      chk("clear", 10'h000, 10'(flg));
   endtask : tc
   task automatic close_out();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   // 21 cases of about 32 cycles each, about three times over for margin
   initial begin
      repeat (2000) @(negedge mclk);
      err_total++;
      close_out();
   end
   initial begin
      void'($urandom(32'h0D70));
      do_reset(12);
      tc(0, 0, 6'h08, 1, 4'h1, 0, 1, 0);
      tc(0, 0, 6'h08, 0, 4'h1, 0, 0, 0);
      tc(3, 0, 6'h08, 1, 4'h0, 0, 0, 3);
      tc(2, 0, 6'h08, 0, 4'h1, 1, 0, 0);
      tc(2, 0, 6'h08, 1, 4'h1, 1, 1, 0);
      tc(3, 2, 6'h01, 1, 4'h0, 0, 0, 3);
      tc(2, 2, 6'h01, 0, 4'h4, 1, 0, 0);
      tc(2, 2, 6'h01, 1, 4'h4, 1, 1, 0);
      tc(1, 2, 6'h01, 1, 4'h4, 0, 1, 1);
      tc(1, 2, 6'h01, 0, 4'h4, 0, 0, 1);
      tc(3, 1, 6'h00, 1, 4'h0, 0, 0, 3);
      tc(1, 1, 6'h02, 1, 4'h0, 0, 0, 1);
      tc(3, 1, 6'h04, 1, 4'h2, 0, 0, 3);
      tc(2, 1, 6'h02, 1, 4'h0, 1, 0, 0);
      tc(3, 1, 6'h06, 0, 4'h2, 1, 0, 0);
      tc(2, 1, 6'h06, 1, 4'h2, 1, 1, 0);
      tc(0, 1, 6'h04, 0, 4'h2, 0, 0, 0);
      tc(3, 3, 6'h10, 1, 4'h0, 1, 0, 0);
      tc(2, 3, 6'h30, 1, 4'h8, 1, 1, 0);
      tc(3, 4, 6'h00, 0, 4'h0, 0, 2, 0);
      tc(1, 5, 6'h00, 0, 4'h0, 0, 2, 0);
      close_out();
   end
endmodule : tb
